// *** rtl/row_chain_pkg.sv ***
// Purpose: shared constants for the serial row driver chain
// Assumes: one system clock at 10 MHz, shift clock sampled as a pin
// Notes: sizes are fixed by the display geometry
package row_chain_pkg;
   localparam int ROWS = 7;
   localparam int CHARS = 4;
   localparam int STAGES = 28;
   localparam int COLUMNS = 5;
   localparam int CLK_HZ = 10000000;
   localparam int SHIFT_MAX_HZ = 3000000;
   localparam logic [27:0] CHAIN_RESET = 28'h0000000;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
endpackage : row_chain_pkg

// *** rtl/bit_buffer.sv ***
// Purpose: two-entry valid/ready buffer for serial data bits
// Assumes: one clock domain
// Notes: full and empty are exact; drain side may stall
`timescale 1ns/1ps
module bit_buffer
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic inData,
   input wire logic inValid,
   output logic inReady,
   output logic outData,
   output logic outValid,
   input wire logic outReady
);
   logic [1:0] mem;
   logic [1:0] count;
   logic wrPtr;
   logic rdPtr;
   logic [1:0] next_mem;
   logic [1:0] next_count;
   logic next_wrPtr;
   logic next_rdPtr;
   logic doWrite;
   logic doRead;

   ////////////////////////////////////////////////////////////
   // handshake and next-state
   always_comb
   begin
      doWrite = inValid && (count != row_chain_pkg::BUF_DEPTH);
      doRead = (count != 2'h0) && outReady;
      next_mem = mem;
      if (doWrite)
      begin
         next_mem[wrPtr] = inData;
      end
      next_wrPtr = doWrite ? ~wrPtr : wrPtr;
      next_rdPtr = doRead ? ~rdPtr : rdPtr;
      next_count = count;
      if (doWrite && !doRead)
      begin
         next_count = count + 2'h1;
      end
      else if (doRead && !doWrite)
      begin
         next_count = count - 2'h1;
      end
   end

   // storage registers
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mem <= 2'h0;
         count <= 2'h0;
         wrPtr <= 1'b0;
         rdPtr <= 1'b0;
      end
      else
      begin
         mem <= next_mem;
         count <= next_count;
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
      end
   end

   assign inReady = (count != row_chain_pkg::BUF_DEPTH);
   assign outValid = (count != 2'h0);
   assign outData = mem[rdPtr];
endmodule : bit_buffer

// *** rtl/serial_row_driver.sv ***
// Purpose: 28-stage serial-to-parallel chain driving row sinks of a 4-char 5x7 display
// Assumes: shift clock, data and blank arrive as pins and are synchronised to clk
// Notes: column anode drive passes through registered; column strobing is the controller's job
//
// Operation
// - twenty-eight stages, one per row sink
// - stage one enables its row sink
// - falling shift clock advances chain one stage
// - first bit lands at rightmost row seven
// - last bit controls leftmost row one
// - column input shared by all four characters
// - last stage drives serial data output
// - blank low disables every row sink
`timescale 1ns/1ps
module serial_row_driver
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic shiftClock,
   input wire logic serialIn,
   input wire logic display_blank_control,
   input wire logic [4:0] column_anode_drive,
   output logic serialOut,
   output logic [27:0] rowSinkEnable,
   output logic [4:0] columnEnergize,
   output logic [27:0] ledLit
);
   logic [1:0] clkSync;
   logic [1:0] dataSync;
   logic [1:0] blankSync;
   logic [4:0] colSync0;
   logic [4:0] colSync1;
   logic prevClock;
   logic [27:0] serial_to_parallel_chain;
   logic [27:0] next_chain;
   logic next_serialOut;
   logic [27:0] next_rowSinkEnable;
   logic [4:0] next_columnEnergize;
   logic [27:0] next_ledLit;
   logic fallEdge;
   logic bufReady;
   logic bufData;
   logic bufValid;
   logic takeBit;
   logic bufWrite;
   logic [1:0] next_clkSync;
   logic [1:0] next_dataSync;
   logic [1:0] next_blankSync;
   logic [4:0] next_colSync0;
   logic [4:0] next_colSync1;
   logic next_prevClock;

   ////////////////////////////////////////////////////////////
   // row gating, shared by the sink and lit outputs
   function automatic logic [27:0] gate_rows(input logic enable, input logic [27:0] rows);
      logic [27:0] gated;
      gated = 28'h0000000;
      if (enable)
      begin
         gated = rows;
      end
      return gated;
   endfunction : gate_rows

   ////////////////////////////////////////////////////////////
   // shift clock: two flops, then a third for the edge compare
   always_comb
   begin
      next_clkSync = {clkSync[0], shiftClock};
      next_prevClock = clkSync[1]; // only the second flop is read
   end

   // shift clock registers; zero after reset, so no false fall
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         clkSync <= 2'h0;
         prevClock <= 1'b0;
      end
      else
      begin
         clkSync <= next_clkSync;
         prevClock <= next_prevClock;
      end
   end

   ////////////////////////////////////////////////////////////
   // serial data: two flops, read only at a detected fall
   always_comb
   begin
      next_dataSync = {dataSync[0], serialIn};
   end

   // serial data registers
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         dataSync <= 2'h0;
      end
      else
      begin
         dataSync <= next_dataSync;
      end
   end

   ////////////////////////////////////////////////////////////
   // blank pin: two flops, sinks stay off until it is seen high
   always_comb
   begin
      next_blankSync = {blankSync[0], display_blank_control};
   end

   // blank registers
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         blankSync <= 2'h0;
      end
      else
      begin
         blankSync <= next_blankSync;
      end
   end

   ////////////////////////////////////////////////////////////
   // column drive: two flops per column bit
   always_comb
   begin
      next_colSync0 = column_anode_drive;
      next_colSync1 = colSync0;
   end

   // column drive registers
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         colSync0 <= 5'h00;
         colSync1 <= 5'h00;
      end
      else
      begin
         colSync0 <= next_colSync0;
         colSync1 <= next_colSync1;
      end
   end

   // high-to-low of the shift clock; data caught at that edge
   assign fallEdge = prevClock && !clkSync[1];

   // a fall is refused only when both entries are taken; the free drain prevents that
   assign bufWrite = fallEdge && bufReady;

   ////////////////////////////////////////////////////////////
   // bit buffer between edge capture and chain, drain always ready
   bit_buffer u_buf
   (
      .clk(clk),
      .nrst(nrst),
      .inData(dataSync[1]),
      .inValid(bufWrite),
      .inReady(bufReady),
      .outData(bufData),
      .outValid(bufValid),
      .outReady(1'b1)
   );

   assign takeBit = bufValid;

   ////////////////////////////////////////////////////////////
   // chain next value; blank never reaches this group
   always_comb
   begin
      next_chain = serial_to_parallel_chain;
      if (takeBit)
      begin
         // new bit enters stage 0; after 28 shifts first bit sits in stage 27
         next_chain = {serial_to_parallel_chain[26:0], bufData};
      end
   end

   // chain register
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         serial_to_parallel_chain <= row_chain_pkg::CHAIN_RESET;
      end
      else
      begin
         serial_to_parallel_chain <= next_chain;
      end
   end

   ////////////////////////////////////////////////////////////
   // output next values, from the chain's next value to save a cycle
   always_comb
   begin
      next_serialOut = next_chain[27];
      // blank gates sinks only, chain itself is untouched
      next_rowSinkEnable = gate_rows(blankSync[1], next_chain);
      next_columnEnergize = colSync1;
      next_ledLit = gate_rows(colSync1 != 5'h00, next_rowSinkEnable);
   end

   // output registers
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         serialOut <= 1'b0;
         rowSinkEnable <= 28'h0000000;
         columnEnergize <= 5'h00;
         ledLit <= 28'h0000000;
      end
      else
      begin
         serialOut <= next_serialOut;
         rowSinkEnable <= next_rowSinkEnable;
         columnEnergize <= next_columnEnergize;
         ledLit <= next_ledLit;
      end
   end
endmodule : serial_row_driver

// *** dv/row_driver_checker.sv ***
// Purpose: port checks of the row driver
// Assumes: lags as handed over
// Notes: bound in the bench top
`timescale 1ns/1ps
module row_driver_checker
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic shiftClock,
   input wire logic display_blank_control,
   input wire logic [4:0] column_anode_drive,
   input wire logic serialOut,
   input wire logic [27:0] rowSinkEnable,
   input wire logic [4:0] columnEnergize,
   input wire logic [27:0] ledLit
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic prevSc;
   logic [3:0] age;
   logic [3:0] next_age;
   //////////////////////////////
   // cycles since a seen fall
   always_comb next_age = (prevSc && !shiftClock) ? 4'h0 : age + 4'(age != 4'hF);
   always_ff @(posedge clk or negedge nrst)
      if (!nrst) {prevSc, age} <= 5'h1F;
      else {prevSc, age} <= {shiftClock, next_age};
   sequence blankOn; $past(display_blank_control, 3); endsequence
   sequence blankHeld; blankOn ##0 $past(display_blank_control, 4); endsequence
   chk_blank_dark: assert property (!$past(display_blank_control, 3) |-> rowSinkEnable == 28'h0)
      else $error("lit while blank");
   chk_col_copy: assert property (columnEnergize == $past(column_anode_drive, 3))
      else $error("column");
   chk_out_last: assert property (blankOn |-> serialOut == rowSinkEnable[27])
      else $error("last stage");
   chk_shift_only: assert property ($changed(serialOut) |-> age inside {[4'h2:4'h6]})
      else $error("shift time");
   chk_idle_hold: assert property (blankHeld ##0 age == 4'hF |-> $stable(rowSinkEnable))
      else $error("idle");
   chk_reset_clear: assert property ($rose(nrst) |-> rowSinkEnable == 28'h0 && !serialOut)
      else $error("reset");
   chk_lit_dark: assert property (columnEnergize == 5'h0 && $past(columnEnergize) == 5'h0 |-> ledLit == 28'h0)
      else $error("dark");
   chk_lit_rows: assert property (|columnEnergize && |$past(columnEnergize) && $stable(rowSinkEnable)
      |-> ledLit == rowSinkEnable)
      else $error("lit");
endmodule : row_driver_checker

// *** dv/column_ctrl_model.sv ***
// Purpose: column strobe controller
// Assumes: moves 1 ns after clk
// Notes: released data shows inverse
`timescale 1ns/1ps
module column_ctrl_model
(
   input wire logic clk,
   output logic shiftClock = 1'h1,
   output logic serialIn = 1'h0,
   output logic [4:0] column_anode_drive = 5'h00
);
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // one bit, clock low for 3 cycles, then high for 4 plus 1 before the next fall
   task automatic shift1(input logic b);
      serialIn = b;
      step(1);
      shiftClock = 1'h0;
      step(3);
      {shiftClock, serialIn} = {1'h1, !b};
      step(4);
   endtask : shift1
   // one column at a time, held for n cycles
   task automatic strobe(input logic [4:0] m, input int n);
      column_anode_drive = m;
      step(n);
   endtask : strobe
endmodule : column_ctrl_model

// *** dv/serial_row_driver_display_chain_tb_top.sv ***
// Purpose: bench of the row driver
// Assumes: 10 MHz clk, seed 44
// Notes: queue mirrors the chain
`timescale 1ns/1ps
module serial_row_driver_display_chain_tb_top;
   logic clk = 1'h0, nrst = 1'h0, blank = 1'h1, shiftClock, serialIn, serialOut;
   logic [4:0] cols, colOut;
   logic [27:0] rows, lit, w, e;
   logic q[$];
   int n_fail = 0, check_count = 0, seed = 44, cyc = 0;
   column_ctrl_model model_u (.clk, .shiftClock, .serialIn, .column_anode_drive(cols));
   serial_row_driver dut_u (.clk, .nrst, .shiftClock, .serialIn, .display_blank_control(blank),
      .column_anode_drive(cols), .serialOut, .rowSinkEnable(rows), .columnEnergize(colOut), .ledLit(lit));
   task automatic chk(input logic [27:0] got, exp);
      check_count++;
      n_fail += int'(got !== exp);
      if (got !== exp) $display("Error at %0t got %h exp %h", $time, got, exp);
   endtask : chk
   task automatic tally_and_finish(input int extra);
      n_fail += extra;
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   initial forever #50 clk = ~clk;
   always @(posedge clk)
      if (++cyc == 3000) tally_and_finish(1);
   // five random loads with strobe and blank
   initial
   begin
      repeat (28) q.push_back(1'h0);
      repeat (8) @(posedge clk);
      #1 nrst = 1'h1;
      for (int c = 0; c < 5; c++)
      begin
         w = 28'($random(seed));
         for (int i = 27; i >= 0; i--)
         begin
            model_u.shift1(w[i]);
            q = {q[1:$], w[i]};
            chk({27'h0, serialOut}, {27'h0, q[0]});
         end
         e = {>>{q}};
         chk(rows, e);
         // on 58 of a 297-cycle slot: 19.5 percent, slot far under 2 ms
         model_u.strobe(5'h01 << c, 58);
         chk(lit, e);
         chk({23'h0, colOut}, {23'h0, 5'h01 << c});
         model_u.strobe(5'h00, 5);
         chk(lit, 28'h0);
         blank = 1'h0;
         model_u.step(5);
         chk(rows, 28'h0);
         blank = 1'h1;
         model_u.step(5);
         chk(rows, e);
      end
      tally_and_finish(0);
   end
endmodule : serial_row_driver_display_chain_tb_top
bind serial_row_driver row_driver_checker chk_u (.clk, .nrst, .shiftClock, .display_blank_control,
   .column_anode_drive, .serialOut, .rowSinkEnable, .columnEnergize, .ledLit);
